/* File: verilog/icc_top.sv */
// input check and channel configuration register with its checks
// Operation
// - parity sense field: 0 even, 1 odd
// - word parity enable checks each input word
// - frame parity takes check bit from frame
// - quad field set runs all four channels
// - quad clear plus select 11: B,C only
// - four per-channel invert fields complement samples
// - bit 3 enables pointer-gap-two alarm
// - bit 2 enables pointer-gap-one alarm
// - bit 1 enables pointer collision alarm
// - enabled unmasked collision shuts outputs off
`timescale 1ns/1ns
module icc_top
  import icc_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic cfg_wr_in,
  input wire logic [ICC_ADDR_W-1:0] cfg_addr_in,
  input wire logic [ICC_REG_W-1:0] cfg_wdata_in,
  input wire logic [1:0] dual_sel_in,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [1:0] data_chan_in,
  input wire logic data_valid_in,
  input wire logic check_bit_pair_in,
  input wire logic frame_in,
  input wire logic fifo_gap_two_in,
  input wire logic fifo_gap_one_in,
  input wire logic fifo_collision_in,
  input wire logic collision_shutoff_en_in,
  input wire logic alarms_unmasked_in,
  output logic [ICC_REG_W-1:0] cfg_rdata_out,
  output logic [DATA_W-1:0] sample_out,
  output logic [1:0] sample_chan_out,
  output logic sample_valid_out,
  output logic [3:0] chan_active_out,
  output logic ptr_gap_two_alert_en_out,
  output logic ptr_gap_one_alert_en_out,
  output logic ptr_collision_alert_en_out,
  output logic [3:0] alarm_status_out,
  output logic outputs_off_out
);
  logic [ICC_REG_W-1:0] ctrl_ff;
  logic [3:0] stat_ff;
  logic [ICC_REG_W-1:0] rdata_ff;
  logic [3:0] active_ff;
  logic [2:0] alert_en_ff;
  logic off_ff;
  logic [3:0] nxt_stat;
  logic [3:0] nxt_active;

  wire logic wr_ctrl;
  wire logic wr_stat;
  wire logic [ICC_REG_W-1:0] rd_sel;
  wire logic odd_sense;
  wire logic word_par_en;
  wire logic frame_par_en;
  wire logic quad_en;
  wire logic [3:0] inv_abcd;
  wire logic gap2_en;
  wire logic gap1_en;
  wire logic coll_en;
  wire logic [3:0] stat_set;
  wire logic [3:0] stat_clr;

  icc_chk_if #(.DATA_W(DATA_W)) chk_bus ();

  if (DATA_W < 1)
  begin : g_bad_width
    $error("icc_top: DATA_W must be positive");
  end

  assign wr_ctrl = cfg_wr_in && (cfg_addr_in == ICC_CFG_IDX);
  assign wr_stat = cfg_wr_in && (cfg_addr_in == ICC_STAT_IDX);
  // unmapped addresses read as zero
  assign rd_sel = (cfg_addr_in == ICC_CFG_IDX) ? ctrl_ff :
                  (cfg_addr_in == ICC_STAT_IDX) ? {12'h000, stat_ff} : ICC_ZERO16;

  assign odd_sense = ctrl_ff[ICC_ODD_BIT];
  assign word_par_en = ctrl_ff[ICC_WORD_PAR_BIT];
  assign frame_par_en = ctrl_ff[ICC_FRAME_PAR_BIT];
  assign quad_en = ctrl_ff[ICC_QUAD_BIT];
  // field bit 7 is channel A, so reverse into A-first order
  assign inv_abcd = {ctrl_ff[ICC_INV_D_BIT], ctrl_ff[ICC_INV_D_BIT+1],
                     ctrl_ff[ICC_INV_A_BIT-1], ctrl_ff[ICC_INV_A_BIT]};
  assign gap2_en = ctrl_ff[ICC_GAP2_BIT];
  assign gap1_en = ctrl_ff[ICC_GAP1_BIT];
  assign coll_en = ctrl_ff[ICC_COLL_BIT];

  assign chk_bus.odd_sense = odd_sense;
  assign chk_bus.chk_en = word_par_en || frame_par_en;
  // frame strobe overrides the dedicated pair when both are enabled
  assign chk_bus.pbit = frame_par_en ? frame_in : check_bit_pair_in;
  assign chk_bus.invert = inv_abcd;
  assign chk_bus.active = active_ff;
  assign chk_bus.data = data_in;
  assign chk_bus.chan = data_chan_in;
  assign chk_bus.valid = data_valid_in;

  icc_word_check #(.DATA_W(DATA_W)) u_check (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .bus(chk_bus)
  );

  // quad clear without the dual select keeps all channels on
  always_comb
  begin
    nxt_active = ICC_QUAD_ACT;
    if (!quad_en && (dual_sel_in == ICC_DUAL_SEL))
    begin
      nxt_active = ICC_DUAL_ACT;
    end
  end

  assign stat_set[ICC_ST_PAR] = chk_bus.par_err;
  assign stat_set[ICC_ST_GAP2] = fifo_gap_two_in && gap2_en;
  assign stat_set[ICC_ST_GAP1] = fifo_gap_one_in && gap1_en;
  assign stat_set[ICC_ST_COLL] = fifo_collision_in && coll_en;
  assign stat_clr = wr_stat ? cfg_wdata_in[3:0] : 4'h0;

  // write one clears; a set in the same cycle wins
  always_comb
  begin
    nxt_stat = (stat_ff & ~stat_clr) | stat_set;
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_ff <= ICC_CFG_RST;
      stat_ff <= ICC_STAT_RST;
      rdata_ff <= ICC_ZERO16;
      active_ff <= ICC_QUAD_ACT;
      alert_en_ff <= {ICC_CFG_RST[ICC_GAP2_BIT], ICC_CFG_RST[ICC_GAP1_BIT], ICC_CFG_RST[ICC_COLL_BIT]};
      off_ff <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (wr_ctrl)
      begin
        ctrl_ff <= cfg_wdata_in;
      end
      stat_ff <= nxt_stat;
      rdata_ff <= rd_sel;
      active_ff <= nxt_active;
      alert_en_ff <= {gap2_en, gap1_en, coll_en};
      off_ff <= stat_ff[ICC_ST_COLL] && collision_shutoff_en_in && alarms_unmasked_in;
    end
  end

  assign cfg_rdata_out = rdata_ff;
  assign sample_out = chk_bus.sample;
  assign sample_chan_out = chk_bus.sample_chan;
  assign sample_valid_out = chk_bus.sample_valid;
  assign chan_active_out = active_ff;
  assign ptr_gap_two_alert_en_out = alert_en_ff[2];
  assign ptr_gap_one_alert_en_out = alert_en_ff[1];
  assign ptr_collision_alert_en_out = alert_en_ff[0];
  assign alarm_status_out = stat_ff;
  assign outputs_off_out = off_ff;

  sequence s_coll_seen;
    clk_en_in && fifo_collision_in && coll_en;
  endsequence
  sequence s_coll_latched;
    clk_en_in && stat_ff[ICC_ST_COLL] && collision_shutoff_en_in && alarms_unmasked_in;
  endsequence

  property p_par_sense;
    @(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && data_valid_in && word_par_en && !frame_par_en
      && ((^{data_in, check_bit_pair_in}) == odd_sense) |=> !chk_bus.par_err;
  endproperty
  a_par_sense: assert property (p_par_sense) else $error("parity flagged on a good word");

  property p_word_par;
    @(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && data_valid_in && word_par_en && !frame_par_en
      && ((^{data_in, check_bit_pair_in}) != odd_sense) |=> chk_bus.par_err ##1 stat_ff[ICC_ST_PAR] || !clk_en_in;
  endproperty
  a_word_par: assert property (p_word_par) else $error("pair parity error not caught");

  property p_frame_par;
    @(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && data_valid_in && frame_par_en
      && ((^{data_in, frame_in}) != odd_sense) |=> chk_bus.par_err;
  endproperty
  a_frame_par: assert property (p_frame_par) else $error("frame parity error not caught");

  property p_quad;
    @(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && quad_en |=> chan_active_out == ICC_QUAD_ACT;
  endproperty
  a_quad: assert property (p_quad) else $error("quad mode not all channels");

  property p_dual;
    @(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && !quad_en && dual_sel_in == ICC_DUAL_SEL |=> chan_active_out == ICC_DUAL_ACT;
  endproperty
  a_dual: assert property (p_dual) else $error("dual mode not B and C");

  property p_invert;
    @(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && data_valid_in && active_ff[data_chan_in] |=>
      sample_valid_out && sample_out == ($past(data_in) ^ {DATA_W{$past(inv_abcd[data_chan_in])}});
  endproperty
  a_invert: assert property (p_invert) else $error("channel inversion wrong");

  property p_gap2;
    @(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && fifo_gap_two_in && !gap2_en && !stat_ff[ICC_ST_GAP2] |=> !stat_ff[ICC_ST_GAP2];
  endproperty
  a_gap2: assert property (p_gap2) else $error("disabled gap-two alarm latched");

  property p_gap1;
    @(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && fifo_gap_one_in && gap1_en |=> stat_ff[ICC_ST_GAP1];
  endproperty
  a_gap1: assert property (p_gap1) else $error("gap-one alarm not latched");

  property p_coll;
    @(posedge mclk_in) disable iff (sys_rst_in)
    s_coll_seen |=> stat_ff[ICC_ST_COLL];
  endproperty
  a_coll: assert property (p_coll) else $error("collision alarm not latched");

  property p_shutoff;
    @(posedge mclk_in) disable iff (sys_rst_in)
    s_coll_latched |=> outputs_off_out;
  endproperty
  a_shutoff: assert property (p_shutoff) else $error("collision did not shut outputs");

  property p_set_wins;
    @(posedge mclk_in) disable iff (sys_rst_in)
    clk_en_in && wr_stat && cfg_wdata_in[ICC_ST_GAP1] && fifo_gap_one_in && gap1_en |=> stat_ff[ICC_ST_GAP1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a same-cycle set");
endmodule

/* File: common/icc_pkg.sv */
// constants for the input check and channel configuration block
package icc_pkg;
  localparam int ICC_ADDR_W = 7;
  localparam int ICC_REG_W = 16;
  localparam logic [6:0] ICC_CFG_IDX = 7'h01;
  localparam logic [6:0] ICC_STAT_IDX = 7'h05;
  localparam logic [15:0] ICC_CFG_RST = 16'h050e;
  localparam logic [3:0] ICC_STAT_RST = 4'h0;
  localparam int ICC_ODD_BIT = 11;
  localparam int ICC_WORD_PAR_BIT = 10;
  localparam int ICC_FRAME_PAR_BIT = 9;
  localparam int ICC_QUAD_BIT = 8;
  localparam int ICC_INV_A_BIT = 7;
  localparam int ICC_INV_D_BIT = 4;
  localparam int ICC_GAP2_BIT = 3;
  localparam int ICC_GAP1_BIT = 2;
  localparam int ICC_COLL_BIT = 1;
  // status register bit positions
  localparam int ICC_ST_PAR = 0;
  localparam int ICC_ST_GAP2 = 1;
  localparam int ICC_ST_GAP1 = 2;
  localparam int ICC_ST_COLL = 3;
  localparam logic [1:0] ICC_DUAL_SEL = 2'h3;
  localparam logic [3:0] ICC_QUAD_ACT = 4'hf;
  localparam logic [3:0] ICC_DUAL_ACT = 4'h6;
  localparam logic [15:0] ICC_ZERO16 = 16'h0000;
endpackage

/* File: common/icc_chk_if.sv */
// carrier between the control block and the word checker
`timescale 1ns/1ns
interface icc_chk_if #(parameter int DATA_W = 16);
  logic odd_sense;
  logic chk_en;
  logic [3:0] invert;
  logic [3:0] active;
  logic [DATA_W-1:0] data;
  logic [1:0] chan;
  logic valid;
  logic pbit;
  logic par_err;
  logic [DATA_W-1:0] sample;
  logic [1:0] sample_chan;
  logic sample_valid;
  modport ctl (output odd_sense, chk_en, invert, active, data, chan, valid, pbit,
               input par_err, sample, sample_chan, sample_valid);
  modport chk (input odd_sense, chk_en, invert, active, data, chan, valid, pbit,
               output par_err, sample, sample_chan, sample_valid);
endinterface

/* File: verilog/icc_word_check.sv */
// per-word parity check and per-channel inversion
`timescale 1ns/1ns
module icc_word_check
  import icc_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  icc_chk_if.chk bus
);
  wire logic [DATA_W-1:0] inv_mask;
  wire logic word_ones_odd;
  wire logic mismatch;
  wire logic chan_on;
  logic par_err_ff;
  logic [DATA_W-1:0] sample_ff;
  logic [1:0] sample_chan_ff;
  logic sample_valid_ff;

  // refused at elaboration so a zero-width word never reaches the checker
  if (DATA_W < 1)
  begin : g_bad_width
    $error("icc_word_check: DATA_W must be positive");
  end

  // complementing the word is the same as swapping the line pairs
  assign inv_mask = {DATA_W{bus.invert[bus.chan]}};
  // total ones over data plus check bit must be odd in odd sense, even otherwise
  assign word_ones_odd = ^{bus.data, bus.pbit};
  assign mismatch = word_ones_odd != bus.odd_sense;
  assign chan_on = bus.active[bus.chan];

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      par_err_ff <= 1'b0;
      sample_ff <= '0;
      sample_chan_ff <= 2'h0;
      sample_valid_ff <= 1'b0;
    end
    else if (clk_en_in)
    begin
      par_err_ff <= bus.valid && bus.chk_en && mismatch;
      sample_ff <= bus.data ^ inv_mask;
      sample_chan_ff <= bus.chan;
      sample_valid_ff <= bus.valid && chan_on;
    end
  end

  assign bus.par_err = par_err_ff;
  assign bus.sample = sample_ff;
  assign bus.sample_chan = sample_chan_ff;
  assign bus.sample_valid = sample_valid_ff;
endmodule

/* File: testbench/icc_src_model.sv */
// parallel sample source that drives words with a chosen parity sense
`timescale 1ns/1ns
module icc_src_model
#(
  parameter int DATA_W = 16
)
(
  input wire logic mclk_in,
  output logic [DATA_W-1:0] data_out,
  output logic [1:0] chan_out,
  output logic valid_out,
  output logic pair_out,
  output logic frame_out
);
  logic pb;
  initial
  begin
    data_out = '0;
    chan_out = 2'h0;
    valid_out = 1'b0;
    pair_out = 1'b0;
    frame_out = 1'b0;
  end
  // one word for one cycle; bad flips the parity on purpose
  task automatic send(input logic [DATA_W-1:0] w, input logic [1:0] ch, input logic odd, input logic use_frame,
                      input logic bad);
    @(posedge mclk_in);
    #1;
    data_out = w;
    chan_out = ch;
    valid_out = 1'b1;
    pb = (^w) ^ odd ^ bad;
    // the unused parity source carries the wrong bit so a wrong selection shows
    frame_out = use_frame ? pb : ~pb;
    pair_out = use_frame ? ~pb : pb;
    @(posedge mclk_in);
    #1;
    // released lines show the inverse rather than the stale word
    valid_out = 1'b0;
    data_out = ~w;
    pair_out = ~pair_out;
    frame_out = ~frame_out;
  endtask
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the input check and channel configuration block
`timescale 1ns/1ns
module tb;
  import icc_pkg::*;
  logic mclk_in = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [15:0] wdata = 16'h0000;
  logic [1:0] dsel = 2'h0;
  logic g2 = 1'b0, g1 = 1'b0, gc = 1'b0, sh_en = 1'b0, unm = 1'b0;
  logic [15:0] din, rdata, smp, cur;
  logic [1:0] dch, sch;
  logic dv, pbit, frm, sv, e2, e1, ec, off;
  logic [3:0] act, st;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [2:0] pm [5] = '{3'b010, 3'b110, 3'b001, 3'b101, 3'b000};
  always #5 mclk_in = ~mclk_in;
  icc_src_model u_src (.mclk_in(mclk_in), .data_out(din), .chan_out(dch), .valid_out(dv), .pair_out(pbit),
    .frame_out(frm));
  icc_top u_dut (.mclk_in(mclk_in), .sys_rst_in(rst), .clk_en_in(ce), .cfg_wr_in(wr), .cfg_addr_in(addr),
    .cfg_wdata_in(wdata), .dual_sel_in(dsel), .data_in(din), .data_chan_in(dch), .data_valid_in(dv),
    .check_bit_pair_in(pbit), .frame_in(frm), .fifo_gap_two_in(g2), .fifo_gap_one_in(g1), .fifo_collision_in(gc),
    .collision_shutoff_en_in(sh_en), .alarms_unmasked_in(unm), .cfg_rdata_out(rdata), .sample_out(smp),
    .sample_chan_out(sch), .sample_valid_out(sv), .chan_active_out(act), .ptr_gap_two_alert_en_out(e2),
    .ptr_gap_one_alert_en_out(e1), .ptr_collision_alert_en_out(ec), .alarm_status_out(st), .outputs_off_out(off));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    if (a == ICC_CFG_IDX)
      cur = d;
    @(posedge mclk_in);
    #1;
    wr = 1'b0;
  endtask
  task automatic reg_rd(input logic [6:0] a, input logic [15:0] exp);
    @(posedge mclk_in);
    #1;
    addr = a;
    @(posedge mclk_in);
    #1;
    chk(rdata, exp);
  endtask
  // sends one word under the current setting and checks the registered sample
  task automatic xfer(input logic [15:0] w, input logic [1:0] ch, input logic bad, input logic [16:0] exp);
    u_src.send(w, ch, cur[ICC_ODD_BIT], cur[ICC_FRAME_PAR_BIT], bad);
    chk({15'h0, sv}, {15'h0, exp[16]});
    if (exp[16])
    begin
      chk(smp, exp[15:0]);
      chk({14'h0, sch}, {14'h0, ch});
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge mclk_in);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    cur = ICC_CFG_RST;
    repeat (10) @(posedge mclk_in);
    #1;
    rst = 1'b0;
    reg_rd(ICC_CFG_IDX, 16'h050e);
    reg_rd(ICC_STAT_IDX, 16'h0000);
    reg_rd(7'h22, 16'h0000);
    chk({12'h0, act}, 16'h000f);
    chk({13'h0, e2, e1, ec}, 16'h0007);
    $display("test reset done");
    // with the enable low a write must not land
    ce = 1'b0;
    reg_wr(ICC_CFG_IDX, 16'h0000);
    ce = 1'b1;
    cur = ICC_CFG_RST;
    reg_rd(ICC_CFG_IDX, 16'h050e);
    $display("test enable done");
    // five of the eight parity settings, a good word then a bad one
    for (int i = 0; i < 5; i++)
    begin
      reg_wr(ICC_CFG_IDX, (ICC_CFG_RST & 16'hf1ff) | {4'h0, pm[i], 9'h000});
      xfer(16'(16'ha5c3 + i), 2'h1, 1'b0, {1'b1, 16'(16'ha5c3 + i)});
      @(posedge mclk_in);
      #1;
      chk({15'h0, st[ICC_ST_PAR]}, 16'h0000);
      xfer(16'(16'h3c01 + i), 2'h2, 1'b1, {1'b1, 16'(16'h3c01 + i)});
      @(posedge mclk_in);
      #1;
      chk({15'h0, st[ICC_ST_PAR]}, {15'h0, pm[i][1] | pm[i][0]});
      reg_wr(ICC_STAT_IDX, 16'h000f);
    end
    $display("test parity done");
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(ICC_CFG_IDX, ICC_CFG_RST | (16'h0080 >> i));
      for (int j = 0; j < 4; j++)
        xfer(16'(16'h1234 ^ j), j[1:0], 1'b0, {1'b1, (i == j) ? ~16'(16'h1234 ^ j) : 16'(16'h1234 ^ j)});
    end
    $display("test invert done");
    reg_wr(ICC_CFG_IDX, ICC_CFG_RST & 16'hfeff);
    dsel = 2'h3;
    repeat (2) @(posedge mclk_in);
    #1;
    chk({12'h0, act}, 16'h0006);
    xfer(16'h0ff0, 2'h0, 1'b0, 17'h0);
    xfer(16'h0ff1, 2'h3, 1'b0, 17'h0);
    xfer(16'h0ff2, 2'h2, 1'b0, {1'b1, 16'h0ff2});
    dsel = 2'h1;
    repeat (2) @(posedge mclk_in);
    #1;
    chk({12'h0, act}, 16'h000f);
    reg_wr(ICC_CFG_IDX, ICC_CFG_RST);
    dsel = 2'h3;
    repeat (2) @(posedge mclk_in);
    #1;
    chk({12'h0, act}, 16'h000f);
    $display("test channels done");
    // one alarm enable at a time, all conditions raised together
    for (int k = 0; k < 3; k++)
    begin
      reg_wr(ICC_CFG_IDX, (ICC_CFG_RST & 16'hfff1) | (16'h0008 >> k));
      g2 = 1'b1;
      g1 = 1'b1;
      gc = 1'b1;
      sh_en = 1'b1;
      unm = (k != 1);
      @(posedge mclk_in);
      #1;
      {g2, g1, gc} = 3'h0;
      @(posedge mclk_in);
      #1;
      chk({12'h0, st}, 16'h0002 << k);
      chk({13'h0, e2, e1, ec}, 16'h0004 >> k);
      @(posedge mclk_in);
      #1;
      chk({15'h0, off}, {15'h0, k == 2});
      reg_rd(ICC_STAT_IDX, 16'h0002 << k);
      reg_wr(ICC_STAT_IDX, 16'h000f);
      repeat (2) @(posedge mclk_in);
      #1;
      chk({11'h0, st, off}, 16'h0000);
    end
    // a clear that meets a fresh set leaves the flag up
    reg_wr(ICC_CFG_IDX, ICC_CFG_RST);
    g1 = 1'b1;
    reg_wr(ICC_STAT_IDX, 16'h000f);
    g1 = 1'b0;
    reg_rd(ICC_STAT_IDX, 16'h0004);
    $display("test alarms done");
    summarize();
  end
endmodule
